// ### logic/serial_port_pkg.sv
// Shared constants, timing figures and state type of the configurable serial port.
//
// Functional notes
// - The port works either as serial bus master or as serial bus slave, and every serial pin turns with that role.
// - Both slave select lines are driven as outputs in master mode; in slave mode only select line 0 is sampled as an input.
// - A configuration input chooses whether the select lines are active low or active high.
// - Two select lines exist, so up to two external slaves can be addressed in master mode.
// - In master mode the master-out line carries the shift register output, in slave mode it feeds the shift register.
// - In master mode the master-in line feeds the shift register, in slave mode the port drives it from the shift register.
// - As master the port makes and drives the serial clock, as slave it takes the clock that the external master drives.
// - The slave ready input takes part in flow control only in master mode and is ignored in slave mode.
// - With ready control on, the slave signals readiness and a burst starts on an edge or a level of ready, as chosen.
// - With ready control on, the master holds back data until the external slave shows it is ready.
// - A transmit buffer and a receive buffer let several words move per software interaction.
package serial_port_pkg;

  // ------------------------------------------------------------------
  // Data path sizes
  // ------------------------------------------------------------------
  localparam int WORD_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 40;
  // A least time, so the cycle count rounds up.
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Positions of the pin inputs inside the synchroniser vector
  // ------------------------------------------------------------------
  localparam int PIN_SCLK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS0 = 3;
  localparam int PIN_READY = 4;
  localparam int PIN_COUNT = 5;

  // ------------------------------------------------------------------
  // Master sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_GAP
  } master_state_e;

endpackage : serial_port_pkg

// ### logic/stream_if.sv
// Valid/ready word stream between the port core and its data buffers.
interface stream_if #(
  parameter int WIDTH = serial_port_pkg::WORD_WIDTH
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : stream_if

// ### logic/word_buffer.sv
// First-in first-out word buffer used for both the transmit and the receive direction.
module word_buffer #(
  parameter int WIDTH = serial_port_pkg::WORD_WIDTH,
  parameter int DEPTH = serial_port_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Filling side
  stream_if.sink wr,
  // Draining side
  stream_if.source rd
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  // Full and empty come from the occupancy register, so they never lie about space.
  assign wr.ready = (count_q != CW'(DEPTH));
  assign rd.valid = (count_q != '0);
  assign rd.data = mem_q[rd_ptr_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // Storage array; pointers wrap naturally, so DEPTH must be a power of two.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr.data;
    end
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : word_buffer

// ### logic/configurable_serial_port.sv
// Master/slave serial peripheral port with ready flow control and transmit and receive buffers.
module configurable_serial_port #(
  parameter int WORD_WIDTH = serial_port_pkg::WORD_WIDTH,
  parameter int FIFO_DEPTH = serial_port_pkg::FIFO_DEPTH,
  parameter int SCLK_HALF = serial_port_pkg::SCLK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic master_mode,
  input wire logic select_active_high,
  input wire logic select_index,
  input wire logic ready_ctrl_en,
  input wire logic ready_edge_mode,
  input wire logic overrun_clear,
  // Transmit words from the user
  input wire logic [WORD_WIDTH-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Received words to the user
  output logic [WORD_WIDTH-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // Status
  output logic busy,
  output logic rx_overrun,
  // Serial clock pin
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  // Master-out line
  input wire logic master_out_line_i,
  output logic master_out_line_o,
  output logic master_out_line_oe,
  // Master-in line
  input wire logic master_in_line_i,
  output logic master_in_line_o,
  output logic master_in_line_oe,
  // Slave select lines
  input wire logic slave_select_0_i,
  output logic slave_select_0_o,
  output logic slave_select_0_oe,
  input wire logic slave_select_1_i,
  output logic slave_select_1_o,
  output logic slave_select_1_oe,
  // Ready from an external slave
  input wire logic slave_ready_input
);

  localparam int BW = (WORD_WIDTH > 1) ? $clog2(WORD_WIDTH) : 1;
  localparam int DW = (SCLK_HALF > 1) ? $clog2(SCLK_HALF) : 1;
  localparam int NP = serial_port_pkg::PIN_COUNT;
  // The select bit leaves reset at the inactive level of the reset polarity, so no false select follows reset.
  localparam logic [NP-1:0] PIN_IDLE = NP'(1) << serial_port_pkg::PIN_SS0;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  stream_if #(.WIDTH(WORD_WIDTH)) tx_in ();
  stream_if #(.WIDTH(WORD_WIDTH)) tx_out ();
  stream_if #(.WIDTH(WORD_WIDTH)) rx_in ();
  stream_if #(.WIDTH(WORD_WIDTH)) rx_out ();

  logic [NP-1:0] pin_meta_q;
  logic [NP-1:0] pin_sync_q;
  logic sclk_prev_q;
  logic ready_prev_q;
  logic sel_prev_q;
  logic mode_q;
  logic pol_q;
  logic target_q;
  logic ready_armed_q;
  logic in_burst_q;
  serial_port_pkg::master_state_e state_q;
  logic [DW-1:0] div_q;
  logic sclk_q;
  logic ss0_q;
  logic ss1_q;
  logic miso_oe_q;
  logic [WORD_WIDTH-1:0] shreg_q;
  logic [BW-1:0] bitcnt_q;
  logic rx_bit_q;
  logic rx_push_q;
  logic [WORD_WIDTH-1:0] rx_word_q;
  logic overrun_q;
  logic busy_q;

  logic sclk_s;
  logic mosi_s;
  logic miso_s;
  logic ready_s;
  logic sel_s;
  logic ready_rise;
  logic tick;
  logic last_bit;
  logic start_ok;
  logic cont_ok;
  logic m_load;
  logic m_sample;
  logic m_shift;
  logic s_sel_rise;
  logic s_sample;
  logic s_shift;
  logic word_done;
  logic tx_pop;

  // ------------------------------------------------------------------
  // Buffers
  // ------------------------------------------------------------------
  // Both directions are buffered so software moves words in bursts.
  word_buffer #(.WIDTH(WORD_WIDTH), .DEPTH(FIFO_DEPTH)) tx_buffer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr(tx_in.sink),
    .rd(tx_out.source)
  );

  word_buffer #(.WIDTH(WORD_WIDTH), .DEPTH(FIFO_DEPTH)) rx_buffer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr(rx_in.sink),
    .rd(rx_out.source)
  );

  // User side of the buffers and the pops and pushes of the core.
  assign tx_in.valid = tx_valid;
  assign tx_in.data = tx_data;
  assign tx_ready = tx_in.ready;
  assign rx_valid = rx_out.valid;
  assign rx_data = rx_out.data;
  assign rx_out.ready = rx_ready;
  assign tx_out.ready = tx_pop;
  assign rx_in.valid = rx_push_q;
  assign rx_in.data = rx_word_q;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Every pin input except select line 1, which is never read, crosses two flops; only the second stage is read by logic.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_meta_q <= PIN_IDLE;
      pin_sync_q <= PIN_IDLE;
    end else begin
      pin_meta_q <= {slave_ready_input, slave_select_0_i, master_in_line_i, master_out_line_i, serial_clock_pin_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign sclk_s = pin_sync_q[serial_port_pkg::PIN_SCLK];
  assign mosi_s = pin_sync_q[serial_port_pkg::PIN_MOSI];
  assign miso_s = pin_sync_q[serial_port_pkg::PIN_MISO];
  assign ready_s = pin_sync_q[serial_port_pkg::PIN_READY];

  // Edge history of the synchronised clock, ready and select.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      ready_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      ready_prev_q <= ready_s;
      sel_prev_q <= sel_s;
    end
  end

  // ------------------------------------------------------------------
  // Role and polarity
  // ------------------------------------------------------------------
  // Role and polarity change only between frames, so a live transfer is never cut by a setting.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
      pol_q <= 1'b0;
    end else if (state_q == serial_port_pkg::ST_IDLE && !sel_s) begin
      mode_q <= master_mode;
      pol_q <= select_active_high;
    end
  end

  // In slave mode select line 0 is the port's own select input.
  assign sel_s = !mode_q && (pin_sync_q[serial_port_pkg::PIN_SS0] == pol_q);

  // ------------------------------------------------------------------
  // Master sequencing strobes
  // ------------------------------------------------------------------
  assign ready_rise = ready_s && !ready_prev_q;
  assign tick = (div_q == DW'(SCLK_HALF - 1));
  assign last_bit = (bitcnt_q == BW'(WORD_WIDTH - 1));
  // Ready gates a burst start only when enabled; the edge form needs a latched rising edge.
  assign start_ok = !ready_ctrl_en || (ready_edge_mode ? ready_armed_q : ready_s);
  // Within a burst the edge form keeps going; the level form rechecks ready before each word.
  assign cont_ok = !ready_ctrl_en || ready_edge_mode || ready_s;
  assign m_load = mode_q && tx_out.valid && rx_in.ready &&
    ((state_q == serial_port_pkg::ST_IDLE && start_ok) || (state_q == serial_port_pkg::ST_GAP && tick && cont_ok));
  assign m_sample = (state_q == serial_port_pkg::ST_SHIFT) && tick && !sclk_q;
  assign m_shift = (state_q == serial_port_pkg::ST_SHIFT) && tick && sclk_q;

  // ------------------------------------------------------------------
  // Slave strobes
  // ------------------------------------------------------------------
  // Mode 0 framing: sample on the rising edge of the external clock, shift on the falling.
  assign s_sel_rise = sel_s && !sel_prev_q;
  assign s_sample = sel_s && sclk_s && !sclk_prev_q;
  assign s_shift = sel_s && !sclk_s && sclk_prev_q;
  assign word_done = (m_shift || s_shift) && last_bit;
  assign tx_pop = m_load || (tx_out.valid && (s_sel_rise || (s_shift && last_bit)));

  // ------------------------------------------------------------------
  // Ready edge latch
  // ------------------------------------------------------------------
  // A rising edge that meets the clearing start is kept, so no trigger is lost.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ready_armed_q <= 1'b0;
    end else if (mode_q && ready_rise) begin
      ready_armed_q <= 1'b1;
    end else if (m_load && state_q == serial_port_pkg::ST_IDLE) begin
      ready_armed_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Master sequencer
  // ------------------------------------------------------------------
  // Generates the serial clock and holds the chosen select through a whole burst.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= serial_port_pkg::ST_IDLE;
      div_q <= '0;
      sclk_q <= 1'b0;
      target_q <= 1'b0;
      in_burst_q <= 1'b0;
    end else begin
      case (state_q)
        serial_port_pkg::ST_IDLE: begin
          div_q <= '0;
          sclk_q <= 1'b0;
          if (m_load) begin
            state_q <= serial_port_pkg::ST_SHIFT;
            target_q <= select_index;
            in_burst_q <= 1'b1;
          end
        end
        serial_port_pkg::ST_SHIFT: begin
          div_q <= tick ? '0 : div_q + 1'b1;
          if (tick) begin
            sclk_q <= !sclk_q;
          end
          if (m_shift && last_bit) begin
            state_q <= serial_port_pkg::ST_GAP;
          end
        end
        serial_port_pkg::ST_GAP: begin
          div_q <= tick ? '0 : div_q + 1'b1;
          if (m_load) begin
            state_q <= serial_port_pkg::ST_SHIFT;
          end else if (tick) begin
            state_q <= serial_port_pkg::ST_IDLE;
            in_burst_q <= 1'b0;
          end
        end
        default: begin
          state_q <= serial_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Shift register
  // ------------------------------------------------------------------
  // One register serves both roles; only the bit sources differ.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shreg_q <= '0;
      bitcnt_q <= '0;
      rx_bit_q <= 1'b0;
    end else if (m_load || s_sel_rise || (s_shift && last_bit)) begin
      // An empty buffer in slave mode sends zeros rather than stale bits.
      shreg_q <= tx_pop ? tx_out.data : '0;
      bitcnt_q <= '0;
    end else if (m_shift || s_shift) begin
      shreg_q <= {shreg_q[WORD_WIDTH-2:0], rx_bit_q};
      bitcnt_q <= bitcnt_q + 1'b1;
    end else if (m_sample) begin
      rx_bit_q <= miso_s;
    end else if (s_sample) begin
      rx_bit_q <= mosi_s;
    end else if (!sel_s && !mode_q) begin
      bitcnt_q <= '0;
    end
  end

  // ------------------------------------------------------------------
  // Receive push and overrun
  // ------------------------------------------------------------------
  // The master never starts a word without room; a slave cannot stall, so it may overrun.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_push_q <= 1'b0;
      rx_word_q <= '0;
      overrun_q <= 1'b0;
    end else begin
      rx_push_q <= word_done && rx_in.ready;
      if (word_done) begin
        rx_word_q <= {shreg_q[WORD_WIDTH-2:0], rx_bit_q};
      end
      if (word_done && !rx_in.ready) begin
        overrun_q <= 1'b1;
      end else if (overrun_clear) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Select and enable levels are registered so the pins never glitch.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ss0_q <= 1'b1;
      ss1_q <= 1'b1;
      miso_oe_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      ss0_q <= (in_burst_q && !target_q) ? pol_q : !pol_q;
      ss1_q <= (in_burst_q && target_q) ? pol_q : !pol_q;
      miso_oe_q <= sel_s;
      busy_q <= (state_q != serial_port_pkg::ST_IDLE) || sel_s;
    end
  end

  assign serial_clock_pin_o = sclk_q;
  assign serial_clock_pin_oe = mode_q;
  assign master_out_line_o = shreg_q[WORD_WIDTH-1];
  assign master_out_line_oe = mode_q;
  assign master_in_line_o = shreg_q[WORD_WIDTH-1];
  assign master_in_line_oe = miso_oe_q;
  assign slave_select_0_o = ss0_q;
  assign slave_select_0_oe = mode_q;
  assign slave_select_1_o = ss1_q;
  assign slave_select_1_oe = mode_q;
  assign busy = busy_q;
  assign rx_overrun = overrun_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_role_pins;
    mode_q |-> !master_in_line_oe;
  endproperty
  a_role_pins: assert property (p_role_pins) else $error("master drives the master-in line");

  property p_select_dir;
    !mode_q |-> (!slave_select_0_oe && !slave_select_1_oe && !serial_clock_pin_oe);
  endproperty
  a_select_dir: assert property (p_select_dir) else $error("slave drives a select or clock pin");

  property p_idle_level;
    (state_q == serial_port_pkg::ST_IDLE && !in_burst_q) ##1 (state_q == serial_port_pkg::ST_IDLE)
      |=> (slave_select_0_o == !$past(pol_q)) && (slave_select_1_o == !$past(pol_q));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle select not at inactive level");

  property p_one_target;
    (state_q == serial_port_pkg::ST_SHIFT && $past(state_q) == serial_port_pkg::ST_SHIFT)
      |-> ((slave_select_0_o == pol_q) != (slave_select_1_o == pol_q));
  endproperty
  a_one_target: assert property (p_one_target) else $error("not exactly one select active");

  property p_first_bit;
    (m_load && mode_q) |=> master_out_line_o == $past(tx_out.data[WORD_WIDTH-1]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first master bit is not the word MSB");

  property p_slave_drive;
    sel_s ##1 sel_s |-> master_in_line_oe;
  endproperty
  a_slave_drive: assert property (p_slave_drive) else $error("selected slave does not drive");

  property p_clock_quiet;
    (mode_q && state_q != serial_port_pkg::ST_SHIFT) |=> !serial_clock_pin_o;
  endproperty
  a_clock_quiet: assert property (p_clock_quiet) else $error("serial clock high outside a word");

  property p_slave_ignores_ready;
    !mode_q |-> !m_load;
  endproperty
  a_slave_ignores_ready: assert property (p_slave_ignores_ready) else $error("slave role started a master word");

  property p_edge_wait;
    (ready_ctrl_en && ready_edge_mode && !ready_armed_q && state_q == serial_port_pkg::ST_IDLE) |-> !m_load;
  endproperty
  a_edge_wait: assert property (p_edge_wait) else $error("edge mode burst without ready edge");

  property p_level_wait;
    (ready_ctrl_en && !ready_edge_mode && !ready_s && state_q != serial_port_pkg::ST_SHIFT) |-> !m_load;
  endproperty
  a_level_wait: assert property (p_level_wait) else $error("level mode word sent while not ready");

  property p_rx_push;
    (word_done && rx_in.ready) |=> rx_in.valid ##1 !rx_in.valid;
  endproperty
  a_rx_push: assert property (p_rx_push) else $error("received word not pushed once");

  property p_free_start;
    (!ready_ctrl_en && mode_q && state_q == serial_port_pkg::ST_IDLE && tx_out.valid && rx_in.ready)
      |=> state_q == serial_port_pkg::ST_SHIFT;
  endproperty
  a_free_start: assert property (p_free_start) else $error("burst did not start with data waiting");

  c_master_word: cover property (mode_q && word_done);
  c_slave_word: cover property (!mode_q && word_done);
  c_edge_start: cover property (ready_ctrl_en && ready_edge_mode && m_load);
  c_overrun: cover property (word_done && !rx_in.ready);

endmodule : configurable_serial_port

// ### dv/spi_far_slave.sv
// Behavioural far slave: a mode 0 shift register that echoes what it hears.
module spi_far_slave (
  // Serial pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel,
  output logic miso,
  // Flow control
  input wire logic stall,
  output logic ready,
  // Words
  input wire logic [serial_port_pkg::WORD_WIDTH-1:0] reply,
  output logic [serial_port_pkg::WORD_WIDTH-1:0] sh
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bit_q = 0;
  logic idle_q = 0;
  // Readiness follows the stall request, so the bench can make this slave slow.
  assign ready = !stall;
  // A fresh reply is loaded at each select; afterwards the shifter echoes the last word heard.
  always @(posedge sel) sh = reply;
  // Sample on the rising edge of the master's clock, shift on its falling edge.
  always @(posedge sclk) if (sel) bit_q = mosi;
  always @(negedge sclk) if (sel) sh = {sh[serial_port_pkg::WORD_WIDTH-2:0], bit_q};
  // A released line shows the inverse of its last bit, so a stale value never passes.
  always @(negedge sel) idle_q = !sh[serial_port_pkg::WORD_WIDTH-1];
  assign miso = sel ? sh[serial_port_pkg::WORD_WIDTH-1] : idle_q;
endmodule : spi_far_slave

// ### dv/configurable_serial_port_bench.sv
// Self-checking bench of the serial port against a far slave model and a bench-driven master.
module configurable_serial_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int W = serial_port_pkg::WORD_WIDTH;
  typedef struct packed {logic [W-1:0] tx; logic [W-1:0] reply; logic idx; logic pol;} row_s;
  logic sys_clk = 0, rst_n = 0, master_mode = 1, select_active_high = 0, select_index = 0;
  logic ready_ctrl_en = 0, ready_edge_mode = 0, overrun_clear = 0, tx_valid = 0, rx_ready = 0;
  logic [W-1:0] tx_data = '0, reply = '0, rx_data, sh;
  logic tx_ready, rx_valid, busy, rx_overrun, serial_clock_pin_o, serial_clock_pin_oe;
  logic master_out_line_o, master_out_line_oe, master_in_line_o, master_in_line_oe;
  logic slave_select_0_o, slave_select_0_oe, slave_select_1_o, slave_select_1_oe;
  logic sclk_b = 0, mosi_b = 0, ss0_b = 1, stall = 1, far_miso, slave_ready_input, wrong_sel = 0;
  int fail_count = 0, tests_run = 0;
  // Wire levels: whoever has its enable up drives; the bench lines stand in for an outside master.
  wire logic serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o : sclk_b;
  wire logic master_out_line_i = master_out_line_oe ? master_out_line_o : mosi_b;
  wire logic master_in_line_i = master_in_line_oe ? master_in_line_o : far_miso;
  wire logic slave_select_0_i = slave_select_0_oe ? slave_select_0_o : ss0_b;
  wire logic slave_select_1_i = slave_select_1_oe ? slave_select_1_o : 1'b1;
  wire logic far_sel = (select_index ? slave_select_1_i : slave_select_0_i) == select_active_high;
  always #5 sys_clk = ~sys_clk;
  configurable_serial_port dut (.sys_clk, .rst_n, .master_mode, .select_active_high, .select_index,
    .ready_ctrl_en, .ready_edge_mode, .overrun_clear, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_ready, .busy, .rx_overrun, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe,
    .master_out_line_i, .master_out_line_o, .master_out_line_oe, .master_in_line_i, .master_in_line_o,
    .master_in_line_oe, .slave_select_0_i, .slave_select_0_o, .slave_select_0_oe, .slave_select_1_i,
    .slave_select_1_o, .slave_select_1_oe, .slave_ready_input);
  spi_far_slave far (.sclk(serial_clock_pin_i), .mosi(master_out_line_i), .sel(far_sel), .miso(far_miso),
    .stall, .ready(slave_ready_input), .reply, .sh);
  // Flags a burst that drives the select it was not told to use; polarity moves only while idle.
  always @(posedge sys_clk) begin
    if (busy && master_mode && (select_index ? slave_select_0_o : slave_select_1_o) == select_active_high) begin
      wrong_sel <= 1;
    end
  end
  task automatic check(string name, logic [W-1:0] exp, logic [W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // One word into the transmit buffer; tx_ready is high because the buffer never fills here.
  task automatic push(logic [W-1:0] d);
    @(negedge sys_clk);
    tx_data = d;
    tx_valid = 1;
    @(negedge sys_clk);
    tx_valid = 0;
  endtask : push
  // Waits a bounded time for a received word, compares it and takes it.
  task automatic pull(logic [W-1:0] exp);
    int n = 0;
    @(negedge sys_clk);
    while (rx_valid !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check("rx_valid", W'(1'b1), W'(rx_valid));
    check("rx_data", exp, rx_data);
    rx_ready = 1;
    @(negedge sys_clk);
    rx_ready = 0;
  endtask : pull
  task automatic settle();
    int n = 0;
    repeat (4) @(negedge sys_clk);
    while (busy !== 1'b0 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check("idle after burst", '0, W'(busy));
  endtask : settle
  initial begin
    row_s rows [4] = '{'{8'hA5, 8'h3C, 1'b0, 1'b0}, '{8'h81, 8'h7E, 1'b1, 1'b0},
      '{8'h5A, 8'hC3, 1'b0, 1'b1}, '{8'h01, 8'hFE, 1'b1, 1'b1}};
    logic [W-1:0] sw = 8'h6B;
    logic [W-1:0] got = '0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1;
    repeat (2) @(negedge sys_clk);
    check("after reset", W'(3'h4), W'({tx_ready, busy, rx_valid}));
    check("master enables", W'(5'h1E), W'({serial_clock_pin_oe, master_out_line_oe, slave_select_0_oe,
      slave_select_1_oe, master_in_line_oe}));
    // Ready is low throughout: with flow control off, bursts must not wait for it.
    foreach (rows[i]) begin
      {select_active_high, select_index, reply} = {rows[i].pol, rows[i].idx, rows[i].reply};
      repeat (2) @(negedge sys_clk);
      check("idle select", W'(!rows[i].pol), W'(rows[i].idx ? slave_select_1_o : slave_select_0_o));
      push(rows[i].tx);
      pull(rows[i].reply);
      settle();
      check("far word", rows[i].tx, sh);
    end
    check("other select", '0, W'(wrong_sel));
    // Two queued words: the echo of the first proves the select stayed active between them.
    {select_active_high, select_index, reply} = {1'b0, 1'b0, 8'h96};
    push(8'hC7);
    push(8'h2B);
    pull(8'h96);
    pull(8'hC7);
    settle();
    check("far word", 8'h2B, sh);
    ready_ctrl_en = 1;
    // Edge trigger first, then level gating; a slow slave holds each word back.
    for (int m = 1; m >= 0; m--) begin
      ready_edge_mode = m[0];
      reply = 8'h2B ^ W'(m);
      stall = 1;
      push(8'h4D);
      repeat (100) @(negedge sys_clk);
      check("held", '0, W'(rx_valid | busy));
      stall = 0;
      pull(8'h2B ^ W'(m));
      settle();
    end
    // Slave role with ready low and flow control on: ready must not matter here.
    stall = 1;
    master_mode = 0;
    repeat (2) @(negedge sys_clk);
    push(8'hE4);
    ss0_b = 0;
    #100;
    check("slave enables", W'(5'h01), W'({serial_clock_pin_oe, master_out_line_oe, slave_select_0_oe,
      slave_select_1_oe, master_in_line_oe}));
    for (int b = W - 1; b >= 0; b--) begin
      mosi_b = sw[b];
      #62.5 sclk_b = 1;
      got[b] = master_in_line_i;
      #62.5 sclk_b = 0;
    end
    #100 ss0_b = 1;
    mosi_b = ~mosi_b;
    check("slave out", 8'hE4, got);
    pull(sw);
    check("overrun", '0, W'(rx_overrun));
    end_of_test();
  end
  // Watchdog: the whole sequence needs about 10 us, so 100 us means a hang.
  initial begin
    #100us;
    fail_count++;
    end_of_test();
  end
endmodule : configurable_serial_port_bench
